// [tuning_pkg.sv]
// constants for the radio tuning configuration register bank
// Functional notes
// R1 - oscillator slope bits 7:6 pick adjust: 11 wide, 10 narrow, 00 none, 01 reserved
// R2 - oscillator slope field is write-only; its read bits are undefined
// R3 - host programs slope field to the wide adjust setting at initialisation
// R4 - gain lock bit 7 disables amplifier gain control, powers down, holds maximum gain
// R5 - host sets write-enable bit 6 of register 20 before writing gain control
// R6 - host should set gain lock bit during initialisation to save power
// R7 - carrier-sense bit 7 overrides the carrier detection result
// R8 - host sets write-enable bit 6 of register 20 before writing carrier sense
// R9 - host writes 0x41 to both clock override registers after every reset
// R10 - synth waits count times 2 us in auto mode without lock signal; reset 0x64
// R11 - 32-bit identity over four read-only bytes, lowest address least significant
// R12 - identity bytes readable only while identity-read enable bit is set
// R13 - host sets identity-read enable only while reading identity bytes
// R14 - host writes zeros to all reserved bit positions
// R15 - writes to gain control and carrier sense ignored while write enable clear
package tuning_pkg;
  localparam logic [5:0] addr_osc_slope   = 6'h26;
  localparam logic [5:0] addr_gain_lock   = 6'h2e;
  localparam logic [5:0] addr_carrier     = 6'h2f;
  localparam logic [5:0] addr_clk_manual  = 6'h32;
  localparam logic [5:0] addr_clk_enables = 6'h33;
  localparam logic [5:0] addr_settle      = 6'h38;
  localparam logic [5:0] addr_id_b0       = 6'h3c;
  localparam logic [5:0] addr_id_b1       = 6'h3d;
  localparam logic [5:0] addr_id_b2       = 6'h3e;
  localparam logic [5:0] addr_id_b3       = 6'h3f;

  localparam int slope_hi = 7;
  localparam int slope_lo = 6;
  localparam int lock_bit = 7;

  localparam logic [1:0] slope_wide = 2'h3;
  localparam logic [1:0] slope_narrow = 2'h2;
  localparam logic [1:0] slope_none = 2'h0;

  localparam logic [7:0] rst_zero   = 8'h00;
  localparam logic [7:0] rst_settle = 8'h64;
  localparam logic [7:0] read_undef = 8'h00;

  // identity value is arbitrary
  localparam logic [31:0] chip_id_default = 32'h5a3c_9617;

  localparam int clk_mhz  = 10;
  localparam int step_us  = 2;
  localparam int step_cyc = step_us * clk_mhz;
  localparam logic [4:0] step_last = 5'(step_cyc - 1);
endpackage

// [settle_timer.sv]
// synthesizer settle delay timer in 2 us steps
`timescale 1ns/1ps
module settle_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       start,
  input  wire logic [7:0] count,
  // status
  output logic            busy,
  output logic            done
);
  logic [4:0] sub_r;
  logic [7:0] steps_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sub_r   <= 5'h00;
      steps_r <= 8'h00;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        sub_r   <= 5'h00;
        steps_r <= count;
        busy    <= (count != 8'h00);
        done    <= (count == 8'h00);
      end else if (busy) begin
        if (sub_r == tuning_pkg::step_last) begin
          sub_r <= 5'h00;
          steps_r <= steps_r - 8'h01;
          if (steps_r == 8'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          sub_r <= sub_r + 5'h01;
        end
      end
    end
  end
endmodule // settle_timer

// [tuning_regs.sv]
// radio tuning configuration and identity register bank
`timescale 1ns/1ps
module tuning_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // analog control bits held elsewhere
  input  wire logic       gain_write_en,
  input  wire logic       id_read_en,
  // synthesizer
  input  wire logic       auto_synth,
  input  wire logic       use_pll_lock,
  input  wire logic       synth_start,
  output logic            synth_waiting,
  output logic            synth_settled,
  // analog controls
  output logic      [1:0] osc_slope_sel,
  output logic            gain_ctl_disable,
  output logic            gain_max_hold,
  output logic            gain_power_down,
  output logic            carrier_override,
  output logic      [7:0] clk_manual,
  output logic      [7:0] clk_enables
);
  logic [7:0] gain_r;
  logic [7:0] carrier_r;
  logic [7:0] settle_r;
  logic [7:0] rdata_nxt;
  logic       t_busy;
  logic       t_done;
  logic [31:0] chip_id;

  assign chip_id = tuning_pkg::chip_id_default;

  // slope field, write-only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_slope_sel <= tuning_pkg::slope_none;
    end else if (reg_wr && reg_addr == tuning_pkg::addr_osc_slope) begin
      osc_slope_sel <= reg_wdata[tuning_pkg::slope_hi:tuning_pkg::slope_lo]; // R1
    end
  end

  // gated registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_r    <= tuning_pkg::rst_zero;
      carrier_r <= tuning_pkg::rst_zero;
    end else if (reg_wr && gain_write_en) begin // R15
      if (reg_addr == tuning_pkg::addr_gain_lock) begin
        gain_r <= reg_wdata;
      end
      if (reg_addr == tuning_pkg::addr_carrier) begin
        carrier_r <= reg_wdata;
      end
    end
  end

  // gain lock and carrier override outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_ctl_disable <= 1'b0;
      gain_max_hold    <= 1'b0;
      gain_power_down  <= 1'b0;
      carrier_override <= 1'b0;
    end else begin
      gain_ctl_disable <= gain_r[tuning_pkg::lock_bit]; // R4
      gain_max_hold    <= gain_r[tuning_pkg::lock_bit]; // R4
      gain_power_down  <= gain_r[tuning_pkg::lock_bit]; // R4
      carrier_override <= carrier_r[tuning_pkg::lock_bit]; // R7
    end
  end

  // clock override registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_manual  <= tuning_pkg::rst_zero;
      clk_enables <= tuning_pkg::rst_zero;
    end else if (reg_wr) begin
      if (reg_addr == tuning_pkg::addr_clk_manual) begin
        clk_manual <= reg_wdata;
      end
      if (reg_addr == tuning_pkg::addr_clk_enables) begin
        clk_enables <= reg_wdata;
      end
    end
  end

  // settle count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= tuning_pkg::rst_settle; // R10
    end else if (reg_wr && reg_addr == tuning_pkg::addr_settle) begin
      settle_r <= reg_wdata;
    end
  end

  settle_timer u_timer (
    .clk   (clk),
    .rst_b (rst_b),
    .start (synth_start && auto_synth && !use_pll_lock), // R10
    .count (settle_r),
    .busy  (t_busy),
    .done  (t_done)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      synth_waiting <= 1'b0;
      synth_settled <= 1'b0;
    end else begin
      synth_waiting <= t_busy;
      synth_settled <= t_done;
    end
  end

  // read mux
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      tuning_pkg::addr_osc_slope:   rdata_nxt = tuning_pkg::read_undef; // R2
      tuning_pkg::addr_gain_lock:   rdata_nxt = gain_r;
      tuning_pkg::addr_carrier:     rdata_nxt = carrier_r;
      tuning_pkg::addr_clk_manual:  rdata_nxt = clk_manual;
      tuning_pkg::addr_clk_enables: rdata_nxt = clk_enables;
      tuning_pkg::addr_settle:      rdata_nxt = settle_r;
      tuning_pkg::addr_id_b0:       rdata_nxt = id_read_en ? chip_id[7:0]   : 8'h00; // R11 R12
      tuning_pkg::addr_id_b1:       rdata_nxt = id_read_en ? chip_id[15:8]  : 8'h00; // R11 R12
      tuning_pkg::addr_id_b2:       rdata_nxt = id_read_en ? chip_id[23:16] : 8'h00; // R11 R12
      tuning_pkg::addr_id_b3:       rdata_nxt = id_read_en ? chip_id[31:24] : 8'h00; // R11 R12
      default:                      rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end
endmodule // tuning_regs

// [tuning_regs_monitor.sv]
// port checker for the tuning register bank
`timescale 1ns/1ps
module tuning_regs_monitor (
  // watched ports
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       gain_write_en,
  input wire logic       id_read_en,
  input wire logic       gain_ctl_disable,
  input wire logic       gain_power_down,
  input wire logic       carrier_override,
  input wire logic [7:0] clk_manual
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  gain_outputs_a: assert property (gain_ctl_disable == gain_power_down)
    else $error("gain outputs differ");
  gain_write_a: assert property (reg_wr && reg_addr == 6'h2e && gain_write_en
    |-> ##2 gain_ctl_disable == $past(reg_wdata[7], 2)) else $error("gain write lost");
  gain_block_a: assert property (reg_wr && reg_addr == 6'h2e && !gain_write_en
    |-> ##2 $stable(gain_ctl_disable)) else $error("gain write not blocked");
  carrier_write_a: assert property (reg_wr && reg_addr == 6'h2f && gain_write_en
    |-> ##2 carrier_override == $past(reg_wdata[7], 2)) else $error("carrier write lost");
  clock_manual_a: assert property (reg_wr && reg_addr == 6'h32
    |=> clk_manual == $past(reg_wdata)) else $error("clock manual wrong");
  id_read_a: assert property (reg_rd && reg_addr[5:2] == 4'hf && id_read_en
    |=> reg_rdata == tuning_pkg::chip_id_default[8*$past(reg_addr[1:0]) +: 8])
    else $error("id byte wrong");
  id_block_a: assert property (reg_rd && reg_addr[5:2] == 4'hf && !id_read_en
    |=> reg_rdata == 8'h00) else $error("id read not gated");
  settle_readback_a: assert property (reg_wr && reg_addr == 6'h38
    ##2 reg_rd && reg_addr == 6'h38 |=> reg_rdata == $past(reg_wdata, 3))
    else $error("settle count readback wrong");
endmodule // tuning_regs_monitor

// [host_model.sv]
// host controller model for the register port
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  // analog control register bits
  output logic            gain_write_en,
  output logic            id_read_en
);
  initial {reg_addr, reg_wdata, reg_wr, reg_rd, gain_write_en, id_read_en} = '0;
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    {reg_wr, reg_rd} = {w, !w};
    @(posedge clk);
    #1;
    {reg_wr, reg_rd} = 2'h0;
    reg_wdata = ~d;
  endtask
  task automatic ctl(input logic g, input logic i);
    @(posedge clk);
    #1;
    gain_write_en = g;
    id_read_en = i;
  endtask
  task automatic init;
    ctl(1'b1, 1'b0);
    xfer(1'b1, 6'h26, 8'hc0);
    xfer(1'b1, 6'h32, 8'h41);
    xfer(1'b1, 6'h33, 8'h41);
    xfer(1'b1, 6'h2e, 8'h80);
  endtask
endmodule // host_model

// [tuning_regs_tb_top.sv]
// self-checking testbench for the tuning register bank
`timescale 1ns/1ps
module tuning_regs_tb_top;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       auto_synth = 1'b0;
  logic       use_pll_lock = 1'b0;
  logic       synth_start = 1'b0;
  logic       reg_wr, reg_rd, gain_write_en, id_read_en, synth_waiting, synth_settled;
  logic       gain_ctl_disable, gain_max_hold, gain_power_down, carrier_override;
  logic [1:0] osc_slope_sel;
  logic [1:0] slopes [3] = '{2'h2, 2'h0, 2'h3};
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, clk_manual, clk_enables, cyc, wcyc;
  int         n_fail = 0;
  int         n_checks = 0;
  always #50 clk = ~clk;
  host_model i_host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .gain_write_en, .id_read_en);
  tuning_regs i_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .gain_write_en, .id_read_en, .auto_synth, .use_pll_lock, .synth_start, .synth_waiting,
    .synth_settled, .osc_slope_sel, .gain_ctl_disable, .gain_max_hold, .gain_power_down,
    .carrier_override, .clk_manual, .clk_enables);
  task automatic check(input string s, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rchk(input string s, input logic [5:0] a, input logic [7:0] e);
    i_host.xfer(1'b0, a, 8'h00);
    check(s, e, reg_rdata);
  endtask
  task automatic results;
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    rchk("settle rst", 6'h38, 8'h64);
    i_host.xfer(1'b1, 6'h2e, 8'h80);
    rchk("gain locked", 6'h2e, 8'h00);
    i_host.xfer(1'b1, 6'h2f, 8'h80);
    rchk("carrier locked", 6'h2f, 8'h00);
    i_host.init;
    rchk("gain", 6'h2e, 8'h80);
    check("gain out", 8'h07, {5'h00, gain_ctl_disable, gain_max_hold, gain_power_down});
    check("clk man", 8'h41, clk_manual);
    check("clk en", 8'h41, clk_enables);
    for (int k = 0; k < 3; k++) begin
      i_host.xfer(1'b1, 6'h26, {slopes[k], 6'h00});
      @(posedge clk);
      #1;
      check("slope", {6'h00, slopes[k]}, {6'h00, osc_slope_sel});
    end
    i_host.xfer(1'b1, 6'h2f, 8'h80);
    rchk("carrier", 6'h2f, 8'h80);
    check("carrier out", 8'h01, {7'h00, carrier_override});
    rchk("id off", 6'h3c, 8'h00);
    i_host.ctl(1'b1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      rchk("id", 6'h3c + 6'(k), tuning_pkg::chip_id_default[8*k +: 8]);
    end
    i_host.ctl(1'b1, 1'b0);
    i_host.xfer(1'b1, 6'h38, 8'h01);
    rchk("settle", 6'h38, 8'h01);
    // manual mode, then lock signal in use, then the auto wait itself
    for (int k = 0; k < 3; k++) begin
      {auto_synth, use_pll_lock} = (k == 0) ? 2'h0 : ((k == 1) ? 2'h3 : 2'h2);
      synth_start = 1'b1;
      @(posedge clk);
      #1;
      synth_start = 1'b0;
      cyc = 8'h00;
      wcyc = 8'h00;
      while (synth_settled !== 1'b1 && cyc < 8'h40) begin
        @(posedge clk);
        #1;
        cyc++;
        if (synth_waiting === 1'b1) wcyc++;
      end
      check("settle time", (k < 2) ? 8'h40 : 8'(tuning_pkg::step_cyc + 1), cyc);
      check("settle wait", (k < 2) ? 8'h00 : 8'(tuning_pkg::step_cyc), wcyc);
    end
    results;
  end
  initial begin
    #100us;
    n_fail++;
    results;
  end
endmodule // tuning_regs_tb_top
bind tuning_regs tuning_regs_monitor i_mon (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .gain_write_en, .id_read_en, .gain_ctl_disable, .gain_power_down,
  .carrier_override, .clk_manual);
